/* File: bench/psgic_cpu_model.sv */
// Model of the CPU cycle timing and the power-fail supervisor.
`timescale 1ns/100ps
module psgic_cpu_model (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Supervisor request
  input  wire logic fail_low,
  // Towards the block
  output logic      s3p1_strobe,
  output logic      save_enable_wdog_start_pin
);
  logic [1:0] phase;
  // A released pin is pulled high by the weak pull-up.
  assign save_enable_wdog_start_pin = fail_low ? 1'b0 : 1'b1;
  // State 3 phase 1 falls once in every four clocks.
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      phase       <= 2'h0;
      s3p1_strobe <= 1'b0;
    end else begin
      phase       <= phase + 2'h1;
      s3p1_strobe <= (phase == 2'h3);
    end
  end
endmodule // psgic_cpu_model

/* File: bench/psgic_ctrl_assertions.sv */
// Checker of the power save gate ports, bound to the top module.
`timescale 1ns/100ps
module psgic_chk (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       reset,
  // Observed ports
  input wire logic       instr_done,
  input wire logic       irq_pending,
  input wire logic [7:0] sfr_rdata,
  input wire logic       cpu_clk_en,
  input wire logic       osc_run,
  input wire logic       wdog_run,
  input wire logic       strobe_level,
  input wire logic       port_latch_hold,
  input wire logic       idle_active,
  input wire logic       powerdown_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_idle_rise;
    $rose(idle_active);
  endsequence
  sequence s_idle_wake;
    idle_active && irq_pending;
  endsequence
  a_idle_gate: assert property (
    idle_active |-> !cpu_clk_en && osc_run) else $error("idle gating");
  a_idle_strobe: assert property (
    idle_active |-> strobe_level && port_latch_hold) else $error("idle pins");
  a_idle_wdog: assert property (
    idle_active |-> !wdog_run) else $error("watchdog ran in idle");
  a_pd_pins: assert property (
    powerdown_active |-> !strobe_level && !osc_run) else $error("pd pins");
  a_pd_stays: assert property (
    powerdown_active |=> powerdown_active) else $error("pd left early");
  a_start_last: assert property (
    s_idle_rise |-> $past(instr_done)) else $error("idle off boundary");
  a_irq_exit: assert property (
    s_idle_wake |=> !idle_active && cpu_clk_en) else $error("no wake");
  a_read_zero: assert property (
    (sfr_rdata & 8'h63) == 8'h00) else $error("self clear bit read");
endmodule // psgic_chk
bind psgic_ctrl psgic_chk chk_u (
  .ref_clk(ref_clk), .reset(reset), .instr_done(instr_done),
  .irq_pending(irq_pending), .sfr_rdata(sfr_rdata),
  .cpu_clk_en(cpu_clk_en), .osc_run(osc_run), .wdog_run(wdog_run),
  .strobe_level(strobe_level), .port_latch_hold(port_latch_hold),
  .idle_active(idle_active), .powerdown_active(powerdown_active));

/* File: bench/psgic_ctrl_tb_top.sv */
// Testbench of the power save gate and idle control block.
`timescale 1ns/100ps
module psgic_ctrl_tb_top
  import psgic_pkg::*;
;
  logic       ref_clk = 1'b0, reset = 1'b1, fail_low = 1'b0;
  logic       sfr_write = 1'b0, sfr_read = 1'b0, instr_done = 1'b0;
  logic       last_ext_code = 1'b0, irq_pending = 1'b0;
  logic       wdog_sw_start = 1'b0;
  logic [7:0] sfr_addr = PWR_CTRL_ADDR, sfr_wdata = 8'h00, sfr_rdata;
  logic       s3p1_strobe, pin, cpu_clk_en, periph_clk_en, osc_run;
  logic       slow_down_req, wdog_run, strobe_force, strobe_level;
  logic       port_latch_hold, port_alt_freeze, port_in_enable;
  logic       port0_float, port2_addr_hold, idle_active, powerdown_active;
  int         errors = 0, total_checks = 0, cycles = 0;
  always #4 ref_clk = ~ref_clk;
  psgic_cpu_model mdl_u (.ref_clk(ref_clk), .reset(reset),
    .fail_low(fail_low), .s3p1_strobe(s3p1_strobe),
    .save_enable_wdog_start_pin(pin));
  psgic_ctrl dut_u (.ref_clk(ref_clk), .reset(reset),
    .sfr_write(sfr_write), .sfr_read(sfr_read), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .s3p1_strobe(s3p1_strobe), .instr_done(instr_done),
    .last_ext_code(last_ext_code), .irq_pending(irq_pending),
    .wdog_sw_start(wdog_sw_start), .save_enable_wdog_start_pin(pin),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .osc_run(osc_run), .slow_down_req(slow_down_req),
    .wdog_run(wdog_run), .strobe_force(strobe_force),
    .strobe_level(strobe_level), .port_latch_hold(port_latch_hold),
    .port_alt_freeze(port_alt_freeze), .port_in_enable(port_in_enable),
    .port0_float(port0_float), .port2_addr_hold(port2_addr_hold),
    .idle_active(idle_active), .powerdown_active(powerdown_active));
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // One instruction; the write strobe stays up for a following one.
  task automatic ins(input logic wr, input logic [7:0] d);
    sfr_write  = wr;
    sfr_wdata  = d;
    instr_done = 1'b1;
    step(1);
  endtask
  task automatic rest;
    sfr_write  = 1'b0;
    instr_done = 1'b0;
    step(1);
  endtask
  task automatic rd(input logic [7:0] exp);
    sfr_read = 1'b1;
    step(1);
    sfr_read = 1'b0;
    chk(sfr_rdata, exp, "register read");
    step(1);
  endtask
  task automatic do_reset(input logic lo);
    fail_low = lo;
    reset    = 1'b1;
    step(3);
    reset    = 1'b0;
    step(3);
  endtask
  task automatic t_blocked;
    do_reset(1'b0);
    chk(wdog_run, 1, "auto start");
    ins(1'b1, 8'h01);
    ins(1'b1, 8'h20);
    rest();
    chk(idle_active, 0, "entry while blocked");
    fail_low = 1'b1;
    step(8);
    chk(wdog_run, 1, "pin change hit watchdog");
    $display("test blocked done");
  endtask
  task automatic t_idle;
    last_ext_code = 1'b1;
    ins(1'b1, 8'h01);
    ins(1'b1, 8'h20);
    chk(idle_active, 1, "idle entry");
    chk(cpu_clk_en, 0, "cpu clock");
    chk(periph_clk_en, 1, "periph clock");
    chk(strobe_level, 1, "idle strobes");
    chk(wdog_run, 0, "watchdog in idle");
    chk(port2_addr_hold, 1, "port 2 address");
    chk(port0_float, 1, "idle port 0 float");
    chk(strobe_force, 1, "idle strobe force");
    chk(port_alt_freeze, 0, "idle alternates run");
    chk(port_in_enable, 1, "idle inputs usable");
    chk(osc_run, 1, "idle oscillator");
    rest();
    step(3);
    chk(idle_active, 1, "idle held");
    irq_pending = 1'b1;
    step(1);
    irq_pending = 1'b0;
    chk(idle_active, 0, "interrupt wake");
    chk(wdog_run, 1, "watchdog resumes");
    last_ext_code = 1'b0;
    $display("test idle done");
  endtask
  task automatic t_refuse;
    ins(1'b1, 8'h21);
    rest();
    chk(idle_active, 0, "arm and start together");
    ins(1'b1, 8'h01);
    ins(1'b0, 8'h00);
    ins(1'b1, 8'h20);
    rest();
    chk(idle_active, 0, "stale arm");
    ins(1'b1, 8'hFF);
    rest();
    chk(powerdown_active, 0, "all bits in one write");
    chk(slow_down_req, 1, "stored slow bit");
    rd(8'h9C);
    sfr_addr = 8'h88;
    ins(1'b1, 8'h00);
    rest();
    rd(8'h00);
    sfr_addr = PWR_CTRL_ADDR;
    rd(8'h9C);
    ins(1'b1, 8'h00);
    rest();
    $display("test refuse done");
  endtask
  task automatic t_pdown;
    last_ext_code = 1'b1;
    ins(1'b1, 8'h03);
    ins(1'b1, 8'h60);
    rest();
    chk(powerdown_active, 1, "both started");
    chk(idle_active, 0, "idle beside pd");
    chk(strobe_level, 0, "pd strobes");
    chk(port0_float, 1, "port 0 float");
    chk(port2_addr_hold, 0, "pd port 2 data");
    chk(strobe_force, 1, "pd strobe force");
    chk(port_alt_freeze, 1, "pd alternates held");
    step(5);
    chk(powerdown_active, 1, "pd held");
    do_reset(1'b1);
    chk(powerdown_active, 0, "reset exit");
    chk(wdog_run, 0, "no auto start");
    wdog_sw_start = 1'b1;
    step(1);
    wdog_sw_start = 1'b0;
    step(1);
    chk(wdog_run, 1, "software start");
    $display("test pdown done");
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    t_blocked();
    t_idle();
    t_refuse();
    t_pdown();
    end_of_test();
  end
endmodule // psgic_ctrl_tb_top

/* File: hdl/psgic_ctrl.sv */
// Power save gate and idle control sequencer, the top of the block.
`timescale 1ns/100ps
module psgic_ctrl
  import psgic_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // Special function register access from the CPU
  input  wire logic       sfr_write,
  input  wire logic       sfr_read,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // Machine cycle timing from the CPU
  input  wire logic       s3p1_strobe,
  input  wire logic       instr_done,
  input  wire logic       last_ext_code,
  // Events
  input  wire logic       irq_pending,
  input  wire logic       wdog_sw_start,
  // External power-fail pin
  input  wire logic       save_enable_wdog_start_pin,
  // Clock gating
  output logic            cpu_clk_en,
  output logic            periph_clk_en,
  output logic            osc_run,
  output logic            slow_down_req,
  // Watchdog control
  output logic            wdog_run,
  // Pin state control
  output logic            strobe_force,
  output logic            strobe_level,
  output logic            port_latch_hold,
  output logic            port_alt_freeze,
  output logic            port_in_enable,
  output logic            port0_float,
  output logic            port2_addr_hold,
  // Status
  output logic            idle_active,
  output logic            powerdown_active
);

  psgic_pin_if pin ();

  psgic_pin_sample u_pin_sample (
    .ref_clk                    (ref_clk),
    .reset                      (reset),
    .save_enable_wdog_start_pin (save_enable_wdog_start_pin),
    .pin                        (pin.sampler)
  );

  assign pin.s3p1_strobe = s3p1_strobe;

  // Register state.
  psgic_mode_type mode;
  psgic_mode_type next_mode;
  psgic_arm_type  idle_arm;
  psgic_arm_type  next_idle_arm;
  psgic_arm_type  pd_arm;
  psgic_arm_type  next_pd_arm;
  logic     [7:0] power_control;
  logic     [7:0] next_power_control;
  logic           idle_pending;
  logic           next_idle_pending;
  logic           pd_pending;
  logic           next_pd_pending;
  logic           wdog_started;
  logic           next_wdog_started;
  logic           ext_code_at_entry;
  logic           next_ext_code_at_entry;
  logic     [7:0] next_sfr_rdata;

  // Decoding of a write to the power control register.
  wire ctrl_hit     = (sfr_addr == PWR_CTRL_ADDR);
  wire ctrl_write   = sfr_write && ctrl_hit;
  wire modes_open   = !pin.save_enable_pin_high;
  wire w_idle_arm   = sfr_wdata[IDLE_ARM_POS];
  wire w_idle_start = sfr_wdata[IDLE_START_POS];
  wire w_pd_arm     = sfr_wdata[PD_ARM_POS];
  wire w_pd_start   = sfr_wdata[PD_START_POS];

  // An arm write must not carry its own start bit.
  wire arm_idle_hit = ctrl_write && modes_open
                      && w_idle_arm && !w_idle_start;
  wire arm_pd_hit   = ctrl_write && modes_open
                      && w_pd_arm && !w_pd_start;

  // A start write counts only in the instruction after the arming one.
  wire start_idle   = ctrl_write && modes_open && (idle_arm == ARM_NEXT)
                      && w_idle_start && !w_idle_arm;
  wire start_pd     = ctrl_write && modes_open && (pd_arm == ARM_NEXT)
                      && w_pd_start && !w_pd_arm;

  // Ages an armed request across instruction boundaries.
  function automatic psgic_arm_type age_arm(input psgic_arm_type cur,
                                            input logic set,
                                            input logic step,
                                            input logic open);
    psgic_arm_type res;
    res = cur;
    if (!open) begin
      res = ARM_NONE;
    end else if (set) begin
      res = step ? ARM_NEXT : ARM_CUR;
    end else if (step) begin
      res = (cur == ARM_CUR) ? ARM_NEXT : ARM_NONE;
    end
    return res;
  endfunction

  always_comb begin
    next_idle_arm = age_arm(idle_arm, arm_idle_hit, instr_done, modes_open);
    next_pd_arm   = age_arm(pd_arm, arm_pd_hit, instr_done, modes_open);
    if (start_idle || start_pd) begin
      next_idle_arm = ARM_NONE;
      next_pd_arm   = ARM_NONE;
    end
  end

  // Start requests wait for the end of their instruction.
  // A start seen on the last cycle enters at once and is not kept, or it
  // would enter the mode again at the first instruction after wake-up.
  assign next_idle_pending = modes_open && !instr_done
                             && (start_idle || idle_pending);
  assign next_pd_pending   = modes_open && !instr_done
                             && (start_pd || pd_pending);

  wire enter_pd   = (start_pd || pd_pending) && instr_done;
  wire enter_idle = (start_idle || idle_pending) && instr_done;

  // Mode sequencing.
  always_comb begin
    next_mode = mode;
    unique case (mode)
      MODE_RUN: begin
        if (modes_open && enter_pd) begin
          next_mode = MODE_PDOWN;
        end else if (modes_open && enter_idle) begin
          next_mode = MODE_IDLE;
        end
      end
      MODE_IDLE: begin
        if (irq_pending) begin
          next_mode = MODE_RUN;
        end
      end
      MODE_PDOWN: begin
        next_mode = MODE_PDOWN;
      end
      default: begin
        next_mode = MODE_RUN;
      end
    endcase
  end

  // Idle and power-down both gate the CPU and take over the strobes.
  function automatic logic low_power(input psgic_mode_type m);
    return (m == MODE_IDLE) || (m == MODE_PDOWN);
  endfunction

  // Code memory source is frozen as the mode is entered.
  assign next_ext_code_at_entry = low_power(mode) ? ext_code_at_entry
                                                  : last_ext_code;

  // Arm and start bits are never stored, so they read as zero.
  assign next_power_control = ctrl_write
                              ? (sfr_wdata & PWR_CTRL_STORED)
                              : power_control;

  assign next_sfr_rdata = (sfr_read && ctrl_hit) ? power_control : 8'h00;

  // Watchdog start comes from the reset-release level or from software.
  assign next_wdog_started = wdog_started || pin.wdog_auto_start
                             || wdog_sw_start;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode              <= MODE_RUN;
      idle_arm          <= ARM_NONE;
      pd_arm            <= ARM_NONE;
      idle_pending      <= 1'b0;
      pd_pending        <= 1'b0;
      power_control     <= PWR_CTRL_RESET;
      wdog_started      <= 1'b0;
      ext_code_at_entry <= 1'b0;
      sfr_rdata         <= 8'h00;
    end else begin
      mode              <= next_mode;
      idle_arm          <= next_idle_arm;
      pd_arm            <= next_pd_arm;
      idle_pending      <= next_idle_pending;
      pd_pending        <= next_pd_pending;
      power_control     <= next_power_control;
      wdog_started      <= next_wdog_started;
      ext_code_at_entry <= next_ext_code_at_entry;
      sfr_rdata         <= next_sfr_rdata;
    end
  end

  // Output decoding from the next mode so that outputs come from flops.
  wire n_idle  = (next_mode == MODE_IDLE);
  wire n_pdown = (next_mode == MODE_PDOWN);
  wire n_low   = low_power(next_mode);
  wire n_ext   = next_ext_code_at_entry;

  // Next values of the outputs, one named wire each.
  wire next_cpu_clk_en      = !n_low;
  wire next_periph_clk_en   = !n_pdown;
  wire next_osc_run         = !n_pdown;
  wire next_slow_down_req   = next_power_control[SLOW_POS];
  wire next_wdog_run        = next_wdog_started && !n_low;
  wire next_strobe_force    = n_low;
  wire next_strobe_level    = n_idle;
  wire next_port_latch_hold = n_low;
  wire next_port_alt_freeze = n_pdown;
  wire next_port_in_enable  = !n_pdown;
  wire next_port0_float     = n_low && n_ext;
  wire next_port2_addr_hold = n_idle && n_ext;

  // The clock gating outputs leave reset with every clock running.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cpu_clk_en    <= 1'b1;
      periph_clk_en <= 1'b1;
      osc_run       <= 1'b1;
      slow_down_req <= 1'b0;
    end else begin
      cpu_clk_en    <= next_cpu_clk_en;
      periph_clk_en <= next_periph_clk_en;
      osc_run       <= next_osc_run;
      slow_down_req <= next_slow_down_req;
    end
  end

  // The watchdog stays stopped until a start is seen after reset.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wdog_run <= 1'b0;
    end else begin
      wdog_run <= next_wdog_run;
    end
  end

  // The pin controls leave reset in their normal running state, except strobe_level, which resets high.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      strobe_force    <= 1'b0;
      strobe_level    <= 1'b1;
      port_latch_hold <= 1'b0;
      port_alt_freeze <= 1'b0;
      port_in_enable  <= 1'b1;
      port0_float     <= 1'b0;
      port2_addr_hold <= 1'b0;
    end else begin
      strobe_force    <= next_strobe_force;
      strobe_level    <= next_strobe_level;
      port_latch_hold <= next_port_latch_hold;
      port_alt_freeze <= next_port_alt_freeze;
      port_in_enable  <= next_port_in_enable;
      port0_float     <= next_port0_float;
      port2_addr_hold <= next_port2_addr_hold;
    end
  end

  // The status outputs mirror the mode register.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      idle_active      <= 1'b0;
      powerdown_active <= 1'b0;
    end else begin
      idle_active      <= n_idle;
      powerdown_active <= n_pdown;
    end
  end

endmodule // psgic_ctrl

/* File: hdl/psgic_pin_if.sv */
// Interface between the enable pin sampler and the main sequencer.
`timescale 1ns/100ps
interface psgic_pin_if;
  logic s3p1_strobe;
  logic save_enable_pin_high;
  logic wdog_auto_start;

  modport sampler (
    input  s3p1_strobe,
    output save_enable_pin_high,
    output wdog_auto_start
  );

  modport ctrl (
    output s3p1_strobe,
    input  save_enable_pin_high,
    input  wdog_auto_start
  );
endinterface

/* File: hdl/psgic_pin_sample.sv */
// Synchroniser and sampler of the save enable / watchdog start pin.
`timescale 1ns/100ps
module psgic_pin_sample
  import psgic_pkg::*;
(
  // Clock and reset
  input  wire logic   ref_clk,
  input  wire logic   reset,
  // Raw pin
  input  wire logic   save_enable_wdog_start_pin,
  // Results towards the sequencer
  psgic_pin_if.sampler pin
);

  // The synchroniser has no reset so that it follows the pin during reset.
  logic sync_first;
  logic sync_second;
  logic level;
  logic start_taken;
  logic auto_start;

  always_ff @(posedge ref_clk) begin
    sync_first  <= save_enable_wdog_start_pin;
    sync_second <= sync_first;
  end

  // The pin level counts only at state 3, phase 1; high is the safe value.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      level <= 1'b1;
    end else if (pin.s3p1_strobe) begin
      level <= sync_second;
    end
  end

  // The level present at reset release is caught once, on the first edge.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      start_taken <= 1'b0;
      auto_start  <= 1'b0;
    end else if (!start_taken) begin
      start_taken <= 1'b1;
      auto_start  <= sync_second;
    end
  end

  assign pin.save_enable_pin_high = level;
  assign pin.wdog_auto_start      = auto_start;

endmodule // psgic_pin_sample

/* File: hdl/psgic_pkg.sv */
// Package with the constants and types of the power save gate block.
package psgic_pkg;

  // Power control register address on the special function bus.
  localparam logic [7:0] PWR_CTRL_ADDR    = 8'h87;
  localparam logic [7:0] PWR_CTRL_RESET   = 8'h00;

  // Bit positions inside the power control register.
  localparam int         IDLE_ARM_POS     = 0;
  localparam int         PD_ARM_POS       = 1;
  localparam int         GF0_POS          = 2;
  localparam int         GF1_POS          = 3;
  localparam int         SLOW_POS         = 4;
  localparam int         IDLE_START_POS   = 5;
  localparam int         PD_START_POS     = 6;
  localparam int         SPARE_POS        = 7;

  // Bits that store what software writes; all others read as zero.
  localparam logic [7:0] PWR_CTRL_STORED  = 8'h9C;

  // Operating mode of the device.
  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_IDLE  = 2'b01,
    MODE_PDOWN = 2'b10
  } psgic_mode_type;

  // Age of an armed entry request, counted in instructions.
  typedef enum logic [1:0] {
    ARM_NONE = 2'b00,
    ARM_CUR  = 2'b01,
    ARM_NEXT = 2'b10
  } psgic_arm_type;

endpackage
